// ===== cfg_mem.sv
// Purpose: store for pwm channel periods and duties
// Assumes: single clock, byte lane write, one registered read port
// Notes:   every word is also visible in parallel for the channel engines
`timescale 1ns/10ps
`include "pwm_sqw_map.svh"
module cfg_mem
  import pwm_sqw_pkg::*;
(
  input  wire logic                  ref_clk,   // block clock
  input  wire logic                  arst_n,    // async reset, active low
  input  wire logic                  wr_en,     // write strobe
  input  wire logic [`MEM_AW-1:0]    wr_addr,   // write index
  input  wire logic [`PWM_W-1:0]     wr_data,   // write data
  input  wire logic [1:0]            wr_be,     // byte lanes of the word
  input  wire logic                  rd_en,     // read strobe
  input  wire logic [`MEM_AW-1:0]    rd_addr,   // read index
  output logic      [`PWM_W-1:0]     rd_data,   // registered read data
  output pwm_word_t [`MEM_DEPTH-1:0] words      // all words, parallel
);

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  pwm_word_t [`MEM_DEPTH-1:0] mem_q;  // zero after reset: outputs stay low

  // each byte lane written on its own strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_q <= '0;
    end else if (wr_en) begin
      if (wr_be[0]) mem_q[wr_addr][7:0]  <= wr_data[7:0];
      if (wr_be[1]) mem_q[wr_addr][15:8] <= wr_data[15:8];
    end
  end

  // read data comes out of a register, one cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end

  assign words = mem_q;

endmodule // cfg_mem

// ===== pin_load_model.sv
// Purpose: external circuitry on the pins, with a period meter
// Assumes: released pins are pulled high
// Notes:   measures period, high time and edges of one chosen pin
`timescale 1ns/10ps
`include "pwm_sqw_map.svh"
module pin_load_model (
  input  wire logic                  ref_clk,
  input  wire logic [`NUM_PINS-1:0]  pin_out,
  input  wire logic [`NUM_PINS-1:0]  pin_oe,
  input  wire logic [`PIN_IDX_W-1:0] sel,
  output logic      [`NUM_PINS-1:0]  pin_in,
  output logic      [15:0]           per_q,
  output logic      [15:0]           hi_q,
  output logic      [15:0]           tog_q
);
  logic        lvl_q = 1'b0;  // last level of the watched pin
  logic [15:0] cnt_q = '0;    // cycles since last rising edge
  logic [15:0] acc_q = '0;    // high cycles since last rising edge
  // a released pin reads high through the pull-up, not its old value
  assign pin_in = (pin_out & pin_oe) | ~pin_oe;
  initial begin
    per_q = '0;
    hi_q  = '0;
    tog_q = '0;
  end
  // meter restarts on each rising edge of the watched pin
  always @(posedge ref_clk) begin
    cnt_q <= cnt_q + 16'h1;
    acc_q <= acc_q + 16'(pin_in[sel]);
    if (pin_in[sel] != lvl_q) tog_q <= tog_q + 16'h1;
    if (pin_in[sel] && !lvl_q) begin
      per_q <= cnt_q;
      hi_q  <= acc_q;
      cnt_q <= 16'h1;
      acc_q <= 16'h1;
    end
    lvl_q <= pin_in[sel];
  end
endmodule // pin_load_model

// ===== pwm_sqw.sv
// Purpose: pwm and square wave alternate functions on general purpose pins
// Assumes: 40 MHz ref_clk, Avalon-MM slave with waitrequest, sync pin inputs
// Notes:   what this block does
// What this block does
// RL1: any pin may carry pwm, twelve at most
// RL2: each pwm has own frequency and duty
// RL3: pwm period software set, fastest 1 MHz
// RL4: pwm duty spans 0 % to 100 %
// RL5: square wave on at most two pins
// RL6: both square wave pins share one frequency
// RL7: each square wave pin has own duty
// RL8: square wave 0 Hz to 4 MHz, 50 %
// RL9: 0 % steady low, 100 % steady high
`timescale 1ns/10ps
`include "pwm_sqw_map.svh"
module pwm_sqw
  import pwm_sqw_pkg::*;
(
  input  wire logic                 ref_clk,          // 40 MHz clock
  input  wire logic                 arst_n,           // async reset, low
  input  wire logic [`ADDR_W-1:0]   avs_address,      // byte address
  input  wire logic                 avs_read,         // read request
  input  wire logic                 avs_write,        // write request
  input  wire logic [31:0]          avs_writedata,    // write data
  input  wire logic [3:0]           avs_byteenable,   // byte lanes
  output logic      [31:0]          avs_readdata,     // read data
  output logic                      avs_waitrequest,  // stall request
  input  wire logic [`NUM_PINS-1:0] pin_in,           // pin levels
  output logic      [`NUM_PINS-1:0] pin_out,          // pin drive level
  output logic      [`NUM_PINS-1:0] pin_oe            // pin drive enable
);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // true when a selector names pin p
  function automatic logic pin_hit(input pin_idx_t sel, input int p);
    pin_hit = (sel == pin_idx_t'(p));
  endfunction

  // merge write data into an old word under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    be_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) be_merge[b*8 +: 8] = wd[b*8 +: 8];
    end
  endfunction

  localparam pwm_word_t PWM_MIN = pwm_word_t'(`PWM_MIN_PER);
  localparam logic [`SQW_W-1:0] SQW_MIN = (`SQW_W)'(`SQW_MIN_PER);

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  logic [7:0] word;        // register word index
  logic       is_mem;      // pwm period / duty page hit
  logic       is_pwm_ctl;  // pwm control page hit
  logic [3:0] ch_sel;      // channel within a page
  logic       wr_go;       // write taken this cycle
  logic       rd_go;       // read issued this cycle
  logic       rd_ack_q;    // read data standing this cycle
  logic       rd_mem_q;    // standing read came from the store
  logic [31:0] rd_reg_q;   // registered register read data
  logic [`PWM_W-1:0] mem_rd;  // store read data

  assign word       = avs_address[`ADDR_W-1:2];
  assign ch_sel     = word[3:0];
  assign is_mem     = (word[7:5] == `W_MEM_PAGE) && (ch_sel < 4'(`PWM_CH));
  assign is_pwm_ctl = (word[7:4] == 4'(`W_PWM_CTRL >> 4)) &&
                      (ch_sel < 4'(`PWM_CH));
  // writes never stall; reads stall exactly one cycle for the store
  assign wr_go           = avs_write;
  assign rd_go           = avs_read & ~rd_ack_q;
  assign avs_waitrequest = avs_read & ~rd_ack_q;
  assign avs_readdata    = rd_mem_q ? {16'h0000, mem_rd} : rd_reg_q;

  // ---------------------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------------------
  logic [`NUM_PINS-1:0]  gpio_out_q;             // gpio levels
  logic [`NUM_PINS-1:0]  gpio_oe_q;              // gpio enables
  logic [`SQW_W-1:0]     sqw_per_q;              // shared square period
  logic [`SQW_CH-1:0]    sqw_en_q;               // square wave enables
  pin_idx_t              sqw_pin_q [`SQW_CH];    // square wave pins
  logic [`SQW_DUTY_W-1:0] sqw_duty_q [`SQW_CH];  // square wave duties
  logic [`PWM_CH-1:0]    pwm_en_q;               // pwm enables
  pin_idx_t              pwm_pin_q [`PWM_CH];    // pwm pins
  logic [31:0]           sqw_ctl_rd;             // square control image
  logic [31:0]           wmerged;                // merged write word

  assign sqw_ctl_rd = {11'h000, sqw_pin_q[1], 3'h0, sqw_pin_q[0], 6'h00,
                       sqw_en_q};
  always_comb begin
    wmerged = '0;
    case (word)
      `W_GPIO_OUT:   wmerged = be_merge(32'(gpio_out_q), avs_writedata,
                                        avs_byteenable);
      `W_GPIO_OE:    wmerged = be_merge(32'(gpio_oe_q), avs_writedata,
                                        avs_byteenable);
      `W_SQW_PERIOD: wmerged = be_merge(32'(sqw_per_q), avs_writedata,
                                        avs_byteenable);
      `W_SQW_CTRL:   wmerged = be_merge(sqw_ctl_rd, avs_writedata,
                                        avs_byteenable);
      `W_SQW_DUTY0:  wmerged = be_merge(32'(sqw_duty_q[0]), avs_writedata,
                                        avs_byteenable);
      `W_SQW_DUTY1:  wmerged = be_merge(32'(sqw_duty_q[1]), avs_writedata,
                                        avs_byteenable);
      default: begin
        wmerged = be_merge({19'h00000, pwm_pin_q[ch_sel], 7'h00,
                            pwm_en_q[ch_sel]}, avs_writedata,
                           avs_byteenable);
      end
    endcase
  end

  // gpio and square wave registers; unmapped writes are dropped
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gpio_out_q    <= '0;
      gpio_oe_q     <= '0;
      sqw_per_q     <= '0;
      sqw_en_q      <= '0;
      sqw_pin_q[0]  <= '0;
      sqw_pin_q[1]  <= '0;
      sqw_duty_q[0] <= `SQW_DUTY_RST;
      sqw_duty_q[1] <= `SQW_DUTY_RST;
    end else if (wr_go) begin
      case (word)
        `W_GPIO_OUT:   gpio_out_q <= wmerged[`NUM_PINS-1:0];
        `W_GPIO_OE:    gpio_oe_q  <= wmerged[`NUM_PINS-1:0];
        `W_SQW_PERIOD: sqw_per_q  <= wmerged[`SQW_W-1:0];  // [RL8]
        `W_SQW_CTRL: begin                                  // [RL5]
          sqw_en_q     <= wmerged[`F_SQW_EN1:`F_EN];
          sqw_pin_q[0] <= wmerged[`F_SQW_PIN0_LO +: `PIN_IDX_W];
          sqw_pin_q[1] <= wmerged[`F_SQW_PIN1_LO +: `PIN_IDX_W];
        end
        `W_SQW_DUTY0:  sqw_duty_q[0] <= wmerged[`SQW_DUTY_W-1:0];  // [RL7]
        `W_SQW_DUTY1:  sqw_duty_q[1] <= wmerged[`SQW_DUTY_W-1:0];  // [RL7]
        default: ;
      endcase
    end
  end

  // pwm channel control: a fixed channel count caps the pwm pins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_en_q <= '0;
      for (int k = 0; k < `PWM_CH; k++) pwm_pin_q[k] <= '0;
    end else if (wr_go && is_pwm_ctl) begin                 // [RL1]
      pwm_en_q[ch_sel]  <= wmerged[`F_EN];
      pwm_pin_q[ch_sel] <= wmerged[`F_PIN_LO +: `PIN_IDX_W];
    end
  end

  // ---------------------------------------------------------------------------
  // pwm period / duty store
  // ---------------------------------------------------------------------------
  pwm_word_t [`MEM_DEPTH-1:0] words;   // all stored words

  cfg_mem u_cfg_mem (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .wr_en   (wr_go && is_mem),                           // [RL2]
    .wr_addr (word[`MEM_AW-1:0]),
    .wr_data (avs_writedata[`PWM_W-1:0]),
    .wr_be   (avs_byteenable[1:0]),
    .rd_en   (rd_go && is_mem),
    .rd_addr (word[`MEM_AW-1:0]),
    .rd_data (mem_rd),
    .words   (words)
  );

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  logic [`NUM_PINS-1:0] pin_lvl_q;  // driven levels
  logic [`NUM_PINS-1:0] pin_oe_q;   // driven enables

  // capture register data on the stalled cycle, release the next
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ack_q <= 1'b0;
      rd_mem_q <= 1'b0;
      rd_reg_q <= '0;
    end else begin
      rd_ack_q <= rd_go;
      rd_mem_q <= rd_go && is_mem;
      if (rd_go) begin
        case (word)
          `W_GPIO_OUT:   rd_reg_q <= 32'(gpio_out_q);
          `W_GPIO_OE:    rd_reg_q <= 32'(gpio_oe_q);
          `W_GPIO_IN:    rd_reg_q <= 32'(pin_in);
          `W_SQW_PERIOD: rd_reg_q <= 32'(sqw_per_q);
          `W_SQW_CTRL:   rd_reg_q <= sqw_ctl_rd;
          `W_SQW_DUTY0:  rd_reg_q <= 32'(sqw_duty_q[0]);
          `W_SQW_DUTY1:  rd_reg_q <= 32'(sqw_duty_q[1]);
          `W_PIN_LEVEL:  rd_reg_q <= 32'(pin_lvl_q);
          default: begin
            // pwm control words read back, anything else reads zero
            rd_reg_q <= is_pwm_ctl ? {19'h00000, pwm_pin_q[ch_sel], 7'h00,
                                      pwm_en_q[ch_sel]} : 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // pwm engines
  // ---------------------------------------------------------------------------
  logic [`PWM_CH-1:0] pwm_lvl_q;  // pwm outputs

  genvar gk;
  generate
    for (gk = 0; gk < `PWM_CH; gk++) begin : g_pwm
      pwm_word_t cnt_q;    // position in the period
      pwm_word_t per_s_q;  // period in use
      pwm_word_t duty_s_q; // high time in use
      pwm_word_t per_eff;  // period clamped to the fastest rate
      assign per_eff = (words[gk] < PWM_MIN) ? PWM_MIN : words[gk];  // [RL3]

      // new settings load only at a period boundary: no runt pulses
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_q    <= '0;
          per_s_q  <= PWM_MIN;
          duty_s_q <= '0;
        end else if (!pwm_en_q[gk] || cnt_q >= per_s_q - 16'h0001) begin
          cnt_q    <= '0;
          per_s_q  <= per_eff;                                   // [RL2]
          duty_s_q <= words[gk + `MEM_DUTY_BASE];                // [RL2]
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end

      // duty 0 never high; duty at or over period never low
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          pwm_lvl_q[gk] <= 1'b0;
        end else begin
          pwm_lvl_q[gk] <= pwm_en_q[gk] && (cnt_q < duty_s_q);  // [RL4] [RL9]
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // square wave engine
  // ---------------------------------------------------------------------------
  logic [`SQW_W-1:0]  sqw_cnt_q;            // shared position
  logic [`SQW_W-1:0]  sqw_per_s_q;          // period in use, 0 = stopped
  logic [`SQW_W-1:0]  sqw_thr_q [`SQW_CH];  // per pin high time
  logic [`SQW_CH-1:0] sqw_lvl_q;            // square outputs
  logic               sqw_wrap;             // period boundary
  logic [`SQW_W-1:0]  sqw_per_eff;          // clamped period

  assign sqw_per_eff = (sqw_per_q < SQW_MIN) ? SQW_MIN : sqw_per_q;  // [RL8]
  assign sqw_wrap    = (sqw_per_s_q == '0) ||
                       (sqw_cnt_q >= sqw_per_s_q - 24'h000001);

  // one counter serves both pins, so a period change hits both alike
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sqw_cnt_q   <= '0;
      sqw_per_s_q <= '0;
    end else if (sqw_per_q == '0) begin                     // [RL8]
      sqw_cnt_q   <= '0;
      sqw_per_s_q <= '0;
    end else if (sqw_wrap) begin
      sqw_cnt_q   <= '0;
      sqw_per_s_q <= sqw_per_eff;                           // [RL6]
    end else begin
      sqw_cnt_q <= sqw_cnt_q + 24'h000001;
    end
  end

  // high time per pin: period times duty fraction, loaded at the boundary
  for (gk = 0; gk < `SQW_CH; gk++) begin : g_sqw
    logic [`SQW_DUTY_W-1:0] duty_c;   // duty clamped to 100 %
    logic [32:0]            prod;     // period times duty
    assign duty_c = (sqw_duty_q[gk] > `SQW_DUTY_FULL) ? `SQW_DUTY_FULL
                                                      : sqw_duty_q[gk];
    assign prod   = 33'(sqw_per_eff) * 33'(duty_c);

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        sqw_thr_q[gk] <= '0;
      end else if (sqw_wrap) begin
        sqw_thr_q[gk] <= prod[`SQW_FRAC_SH +: `SQW_W];      // [RL7]
      end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        sqw_lvl_q[gk] <= 1'b0;
      end else begin
        sqw_lvl_q[gk] <= sqw_en_q[gk] && (sqw_per_s_q != '0) &&
                         (sqw_cnt_q < sqw_thr_q[gk]);       // [RL9]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // pin multiplexer
  // ---------------------------------------------------------------------------
  pin_func_t            func [`NUM_PINS];  // function per pin
  logic [`NUM_PINS-1:0] lvl_d;             // next pin level
  logic [`NUM_PINS-1:0] oe_d;              // next pin enable

  // square wave wins over pwm, lower channel wins among pwm
  always_comb begin
    for (int p = 0; p < `NUM_PINS; p++) begin
      func[p]  = FUNC_GPIO;
      lvl_d[p] = gpio_out_q[p];
      oe_d[p]  = gpio_oe_q[p];
      for (int k = `PWM_CH - 1; k >= 0; k--) begin
        if (pwm_en_q[k] && pin_hit(pwm_pin_q[k], p)) begin  // [RL1]
          func[p]  = FUNC_PWM;
          lvl_d[p] = pwm_lvl_q[k];
        end
      end
      for (int s = `SQW_CH - 1; s >= 0; s--) begin
        if (sqw_en_q[s] && pin_hit(sqw_pin_q[s], p)) begin  // [RL5]
          func[p]  = FUNC_SQW;
          lvl_d[p] = sqw_lvl_q[s];
        end
      end
      // an alternate function always drives its pin
      if (func[p] != FUNC_GPIO) oe_d[p] = 1'b1;
    end
  end

  // pin drive comes from flip-flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_lvl_q <= '0;
      pin_oe_q  <= '0;
    end else begin
      pin_lvl_q <= lvl_d;
      pin_oe_q  <= oe_d;
    end
  end

  assign pin_out = pin_lvl_q;
  assign pin_oe  = pin_oe_q;

endmodule // pwm_sqw

// ===== pwm_sqw_map.svh
// Purpose: register word indices, field positions, resets and timing counts
// Assumes: 32-bit Avalon-MM data, byte address = 4 * word index
// Notes:   definitions only, included by pwm_sqw_pkg and the design modules
`ifndef PWM_SQW_MAP_SVH
`define PWM_SQW_MAP_SVH

// ---------------------------------------------------------------------------
// geometry
// ---------------------------------------------------------------------------
`define NUM_PINS        19          // general purpose pins
`define PIN_IDX_W       5           // width of a pin selector
`define PWM_CH          12          // pins that may carry pwm at once
`define SQW_CH          2           // pins that may carry the square wave
`define PWM_W           16          // pwm period / duty width (cycles)
`define SQW_W           24          // square wave period width (cycles)
`define SQW_DUTY_W      9           // square wave duty in 1/256 of period
`define MEM_DEPTH       32          // channel config store depth
`define MEM_AW          5           // channel config store address width
`define ADDR_W          10          // avalon byte address width

// ---------------------------------------------------------------------------
// register word indices (byte address = index * 4)
// ---------------------------------------------------------------------------
`define W_GPIO_OUT      8'h00       // gpio output levels
`define W_GPIO_OE       8'h01       // gpio output enables
`define W_GPIO_IN       8'h02       // pin input levels, read only
`define W_SQW_PERIOD    8'h03       // shared square wave period, 0 = stop
`define W_SQW_CTRL      8'h04       // square wave enables and pins
`define W_SQW_DUTY0     8'h05       // square wave duty, first pin
`define W_SQW_DUTY1     8'h06       // square wave duty, second pin
`define W_PIN_LEVEL     8'h07       // driven pin levels, read only
`define W_PWM_CTRL      8'h20       // +k: pwm channel k enable and pin
`define W_MEM_PAGE      3'b010      // word[7:5] of pwm period/duty page
`define MEM_DUTY_BASE   5'h10       // store index of pwm duty 0

// ---------------------------------------------------------------------------
// field positions and resets
// ---------------------------------------------------------------------------
`define F_EN            0           // enable bit in a control word
`define F_PIN_LO        8           // pin selector low bit (pwm ctrl)
`define F_SQW_EN1       1           // second square wave enable
`define F_SQW_PIN0_LO   8           // first square wave pin selector
`define F_SQW_PIN1_LO   16          // second square wave pin selector
`define SQW_DUTY_RST    9'h080      // 50 % mark-space ratio
`define SQW_DUTY_FULL   9'h100      // 100 % high
`define SQW_FRAC_SH     8           // duty fraction shift

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define CLK_HZ          40000000    // ref_clk rate
`define PWM_MAX_HZ      1000000     // fastest pwm repetition
`define SQW_MAX_HZ      4000000     // fastest square wave
`define PWM_MIN_PER     (`CLK_HZ / `PWM_MAX_HZ)
`define SQW_MIN_PER     (`CLK_HZ / `SQW_MAX_HZ)

`endif

// ===== pwm_sqw_monitor.sv
// Purpose: port checks of the pwm and square wave block
// Assumes: the master holds a read until waitrequest is low
// Notes:   bound to every pwm_sqw instance
`timescale 1ns/10ps
`include "pwm_sqw_map.svh"
module pwm_sqw_monitor (
  input wire logic                 ref_clk,
  input wire logic                 arst_n,
  input wire logic [`ADDR_W-1:0]   avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic [`NUM_PINS-1:0] pin_out,
  input wire logic [`NUM_PINS-1:0] pin_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // --------------------------------------------------------------
  // bus handshake: one stall cycle per read, none per write
  // --------------------------------------------------------------
  sequence rd_start; $rose(avs_read); endsequence
  sequence rd_done;  avs_read && !avs_waitrequest; endsequence
  rd_first_wait_a: assert property (rd_start |-> avs_waitrequest)
    else $error("read not stalled in its first cycle");
  rd_wait_one_a: assert property (
    rd_start |-> avs_waitrequest ##1 rd_done)
    else $error("read not answered after one stall");
  wr_no_wait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  wait_cause_a: assert property (avs_waitrequest |-> avs_read)
    else $error("stall without a read");
  // unmapped words and reserved bits read as zero
  unmapped_rd_a: assert property (
    rd_done and avs_address[9:2] == 8'hff |-> avs_readdata == 32'h0)
    else $error("unmapped word read nonzero");
  gpio_rsv_a: assert property (
    rd_done and avs_address[9:2] == 8'h00 |-> avs_readdata[31:19] == 13'h0)
    else $error("reserved gpio bits nonzero");
  // --------------------------------------------------------------
  // pins: drive enables move only in answer to software writes
  // --------------------------------------------------------------
  oe_cause_a: assert property (
    $changed(pin_oe) |-> $past(avs_write) || $past(avs_write, 2)
                         || $past(avs_write, 3))
    else $error("pin enable changed with no write");
  rst_pins_a: assert property (
    $rose(arst_n) |-> pin_oe == '0 && pin_out == '0)
    else $error("pins not quiet after reset");
endmodule // pwm_sqw_monitor

bind pwm_sqw pwm_sqw_monitor pwm_sqw_monitor_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pin_out(pin_out), .pin_oe(pin_oe));

// ===== pwm_sqw_pkg.sv
// Purpose: shared types of the pwm and square wave block
// Assumes: pwm_sqw_map.svh gives all numbers
// Notes:   types only
`include "pwm_sqw_map.svh"
package pwm_sqw_pkg;
  // function currently carried by a pin
  typedef enum logic [1:0] {FUNC_GPIO, FUNC_PWM, FUNC_SQW} pin_func_t;
  typedef logic [`PIN_IDX_W-1:0] pin_idx_t;   // pin selector
  typedef logic [`PWM_W-1:0]     pwm_word_t;  // pwm period or duty
endpackage

// ===== tb_pwm_sqw.sv
// Purpose: register driven tests of the pwm and square wave block
// Assumes: 40 MHz clock, no request during reset
// Notes:   waveforms are judged by the pin load meter
`timescale 1ns/10ps
`include "pwm_sqw_map.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module tb_pwm_sqw;
  logic                  ref_clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic [`ADDR_W-1:0]    avs_address = '0;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = '0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [`NUM_PINS-1:0]  pin_in, pin_out, pin_oe;
  logic [`PIN_IDX_W-1:0] sel = '0;
  logic [15:0]           per_q, hi_q, tog_q, t0;
  int                    n_fail = 0, n_tests = 0, cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  pwm_sqw pwm_sqw_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
  pin_load_model pin_load_model_inst (.ref_clk(ref_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .sel(sel), .pin_in(pin_in), .per_q(per_q),
    .hi_q(hi_q), .tog_q(tog_q));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard: the tests need about 1700 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // one bus cycle, entered just after a rising edge
  task automatic acc(input logic w, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    `CHK("readdata", e, q)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  initial begin
    cyc(10);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rd(10'h000, 32'h0);
    rd(10'h00c, 32'h0);
    rd(10'h014, 32'h80);
    rd(10'h018, 32'h80);
    rd(10'h3fc, 32'h0);
    $display("test reset done");
    wr(10'h004, 32'h3);
    wr(10'h000, 32'h1);
    cyc(4);
    `CHK("pin_oe", 19'h3, pin_oe)
    rd(10'h008, 32'h7fffd);
    sel <= 5'd1;
    wr(10'h100, 32'h10);
    wr(10'h140, 32'd10);
    wr(10'h080, 32'h101);
    cyc(130);
    `CHK("pwm period", 16'd40, per_q)
    `CHK("pwm high", 16'd10, hi_q)
    wr(10'h100, 32'd100);
    wr(10'h140, 32'd30);
    rd(10'h100, 32'd100);
    cyc(250);
    `CHK("pwm period", 16'd100, per_q)
    `CHK("pwm high", 16'd30, hi_q)
    for (int k = 0; k < 2; k++) begin
      wr(10'h140, k ? 32'd100 : 32'd0);
      cyc(220);
      t0 = tog_q;
      cyc(200);
      `CHK("steady edges", t0, tog_q)
      `CHK("steady level", 1'(k), pin_out[1])
    end
    $display("test pwm done");
    for (int k = 0; k < 12; k++) wr(10'(128 + 4*k), 32'h1 | 32'((k+7) << 8));
    cyc(4);
    `CHK("pwm pin_oe", 12'hfff, pin_oe[18:7])
    for (int k = 0; k < 12; k++) wr(10'(128 + 4*k), 32'h0);
    cyc(4);
    `CHK("gpio pin_oe", 19'h3, pin_oe)
    rd(10'h01c, 32'h1);
    $display("test twelve done");
    wr(10'h00c, 32'd20);
    wr(10'h018, 32'h40);
    wr(10'h010, 32'h00060503);
    sel <= 5'd5;
    cyc(80);
    `CHK("sqw period", 16'd20, per_q)
    `CHK("sqw high", 16'd10, hi_q)
    sel <= 5'd6;
    cyc(80);
    `CHK("sqw period", 16'd20, per_q)
    `CHK("sqw high", 16'd5, hi_q)
    wr(10'h00c, 32'd4);
    cyc(60);
    `CHK("sqw period", 16'd10, per_q)
    sel <= 5'd5;
    cyc(60);
    `CHK("sqw period", 16'd10, per_q)
    `CHK("sqw high", 16'd5, hi_q)
    wr(10'h00c, 32'h0);
    cyc(40);
    `CHK("sqw stopped", 2'b00, pin_out[6:5])
    $display("test square wave done");
    report_and_stop();
  end
endmodule // tb_pwm_sqw
